// >>> sspi_pkg.sv
// shared constants and types of the serial port in its spi mode
package sspi_pkg;

    // ----------------
    // register byte offsets
    // ----------------
    localparam logic [7:0] OFS_CTRL_A   = 8'h00;
    localparam logic [7:0] OFS_CTRL_B   = 8'h04;
    localparam logic [7:0] OFS_DATA     = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // ----------------
    // field positions
    // ----------------
    localparam int CA_MODE_LSB  = 5;
    localparam int CA_DEB_LSB   = 2;
    localparam int CA_EN        = 1;
    localparam int CA_INC       = 0;
    localparam int CB_SPARE_LSB = 6;
    localparam int CB_POL       = 5;
    localparam int CB_EDGE      = 4;
    localparam int CB_ORDER     = 3;
    localparam int CB_SELECT_PIN_ENABLE      = 2;
    localparam int CB_WRITE_COLLISION_FLAG      = 1;
    localparam int CB_TRF       = 0;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_COLL     = 1;
    localparam int IRQ_INC      = 2;

    // ----------------
    // reset values
    // ----------------
    localparam logic [2:0] MODE_RST  = 3'h7;
    localparam logic [1:0] DEB_RST   = 2'h0;
    localparam logic [1:0] SPARE_RST = 2'h0;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [2:0] MASK_RST  = 3'h0;

    // ----------------
    // operating modes
    // ----------------
    localparam logic [2:0] MODE_DIV4    = 3'h0;
    localparam logic [2:0] MODE_DIV16   = 3'h1;
    localparam logic [2:0] MODE_DIV64   = 3'h2;
    localparam logic [2:0] MODE_SUB     = 3'h3;
    localparam logic [2:0] MODE_TIMER   = 3'h4;
    localparam logic [2:0] MODE_SLAVE   = 3'h5;
    localparam logic [2:0] MODE_TWOWIRE = 3'h6;
    localparam logic [2:0] MODE_OFF     = 3'h7;

    // ----------------
    // timing: half periods of the master clock in hclk cycles
    // ----------------
    localparam logic [15:0] HALF_DIV4     = 16'h0002;
    localparam logic [15:0] HALF_DIV16    = 16'h0008;
    localparam logic [15:0] HALF_DIV64    = 16'h0020;
    localparam logic [15:0] HALF_SUB_DEF  = 16'h0bec;
    localparam logic [3:0]  BITS_PER_XFER = 4'h8;
    localparam logic [3:0]  LAST_BIT      = 4'h7;
    localparam logic [4:0]  LAST_EDGE     = 5'h0f;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } sspi_state_e;

endpackage

// >>> sspi_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sspi_sync
    import sspi_pkg::*;
#(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= RST;
            q    <= RST;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// >>> sspi_rate.sv
// master bit clock divider, one pulse per serial clock half period
`timescale 1ns/1ps
module sspi_rate
    import sspi_pkg::*;
#(
    parameter logic [15:0] SUB_HALF = HALF_SUB_DEF
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       run,
    input  wire logic [2:0] mode,
    input  wire logic       timer_match,
    output logic            half_tick
);
    logic [15:0] cnt;
    wire  [15:0] limit;
    wire         cnt_end;
    wire         use_timer;

    // timer mode: each match toggles the clock, giving match rate / 2
    assign use_timer = (mode == MODE_TIMER);
    assign limit     = (mode == MODE_DIV4)  ? HALF_DIV4  :
                       (mode == MODE_DIV16) ? HALF_DIV16 :
                       (mode == MODE_DIV64) ? HALF_DIV64 : SUB_HALF;
    assign cnt_end   = (cnt == limit - 16'h0001);
    assign half_tick = run & (use_timer ? timer_match : cnt_end);

    // restarts on every transfer so in the divider modes the first edge has a fixed delay; timer mode waits for timer_match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 16'h0000;
        end else if (!run || cnt_end) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule

// >>> sspi_top.sv
// serial port in spi mode with ahb-lite register slave
// What this block does
// RULE1: one register set; mode field picks spi or two-wire
// RULE2: full duplex exchange, working as master or as slave
// RULE3: master starts every transfer and alone drives the serial clock
// RULE4: a single slave select line; more slaves need general pins
// RULE5: select enable 1 uses the select pin, 0 leaves it floating
// RULE6: enable bit turns the port on or off, keeping configuration
// RULE7: control bit picks lsb first or msb first shifting
// RULE8: capture edge selectable as rising or falling serial clock edge
// RULE9: one 8-bit buffer holds outgoing and incoming byte
// RULE10: software loads the byte to send before the transfer starts
// RULE11: received byte is read from the same buffer after completion
// RULE12: four lines: data in, data out, clock, active-low select
// RULE13: spi pins act only when the pin function selects this port
// RULE14: pin direction depends on master/slave, enable and select enable
// RULE15: modes 0-4 master clocks, 5 spi slave, 6 two-wire, 7 off
// RULE16: done flag set by hardware at transfer end, cleared by software
// RULE17: buffer write during a transfer is dropped and flags collision
// RULE18: polarity 0 idles clock high, 1 idles low; edge bit picks capture
// RULE19: exactly eight bits each way, one per serial clock cycle
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module sspi_top
    import sspi_pkg::*;
#(
    parameter logic [15:0] SUB_HALF = HALF_SUB_DEF
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        pin_func_sel,
    input  wire logic        timer_match,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe,
    input  wire logic        slave_select_n_in,
    output logic             slave_select_n_out,
    output logic             slave_select_n_oe
);
    // ----------------
    // registers
    // ----------------
    logic [2:0]  port_mode_field;
    logic [1:0]  twowire_debounce_field;
    logic        module_enable_bit;
    logic        slave_incomplete_flag;
    logic [1:0]  spare_bits;
    logic        clock_idle_polarity;
    logic        capture_edge_select;
    logic        bit_order_select;
    logic        select_pin_enable;
    logic        write_collision_flag;
    logic        transfer_done_flag;
    logic [7:0]  serial_data_buffer;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;

    // ----------------
    // bus and engine state
    // ----------------
    logic [1:0]  take_dly;
    logic [1:0]  done_dly;
    logic        dp_write;
    logic        rd_wait;
    logic [7:0]  dp_addr;
    sspi_state_e state;
    logic [4:0]  edge_cnt;
    logic [3:0]  bit_cnt;
    logic        cap_bit;
    logic        sck_lvl;
    logic        sck_d;
    logic        scs_d;
    logic        sck_s;
    logic        sdi_s;
    logic        scs_s;
    logic        half_tick;

    function automatic logic [7:0] shift_in(input logic [7:0] cur,
                                            input logic       b,
                                            input logic       msb_first);
        shift_in = msb_first ? {cur[6:0], b} : {b, cur[7:1]};
    endfunction

    sspi_sync #(
        .W   (3),
        .RST (3'h4)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({slave_select_n_in, sdi_in, sck_in}),
        .q       ({scs_s, sdi_s, sck_s})
    );

    // ----------------
    // bus decode
    // ----------------
    wire         acc     = hsel & hready & htrans[1];
    wire         wr_a    = dp_write & (dp_addr == OFS_CTRL_A);
    wire         wr_b    = dp_write & (dp_addr == OFS_CTRL_B);
    wire         wr_data = dp_write & (dp_addr == OFS_DATA);
    wire         wr_stat = dp_write & (dp_addr == OFS_IRQ_STAT);
    wire         wr_mask = dp_write & (dp_addr == OFS_IRQ_MASK);
    wire [7:0]   ctrl_a_rd = {port_mode_field, 1'b0, twowire_debounce_field,
                              module_enable_bit, slave_incomplete_flag};
    wire [7:0]   ctrl_b_rd = {spare_bits, clock_idle_polarity,
                              capture_edge_select, bit_order_select,
                              select_pin_enable, write_collision_flag,
                              transfer_done_flag};
    wire [7:0]   rd_byte =
        (dp_addr == OFS_CTRL_A)   ? ctrl_a_rd :
        (dp_addr == OFS_CTRL_B)   ? ctrl_b_rd :
        (dp_addr == OFS_DATA)     ? serial_data_buffer :
        (dp_addr == OFS_IRQ_STAT) ? {5'h00, irq_status} :
        (dp_addr == OFS_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

    // ----------------
    // mode and pin decode
    // ----------------
    wire is_master = (port_mode_field <= MODE_TIMER);                // RULE15
    wire is_slave  = (port_mode_field == MODE_SLAVE);                // RULE15
    // two-wire and off modes leave the spi engine parked
    wire engine_on = module_enable_bit & (is_master | is_slave);     // RULE1
    wire pins_on   = pin_func_sel & engine_on;                       // RULE13
    wire slave_sel = select_pin_enable ? ~scs_s : 1'b1;              // RULE5
    wire slave_go  = pins_on & is_slave & slave_sel;
    wire idle_lvl  = ~clock_idle_polarity;                           // RULE18
    wire cap_rise  = (clock_idle_polarity == capture_edge_select);   // RULE8

    // ----------------
    // edge and event decode
    // ----------------
    wire m_edge    = (state == ST_SHIFT) & half_tick;                // RULE3
    wire s_edge    = slave_go & (sck_s ^ sck_d);
    wire edge_ev   = m_edge | s_edge;
    wire edge_rise = is_master ? ~sck_lvl : sck_s;
    wire cap_type  = (edge_rise == cap_rise);
    wire bits_left = (bit_cnt < BITS_PER_XFER);
    wire capture   = edge_ev & cap_type & bits_left;                 // RULE19
    wire shift_ev  = edge_ev & ~cap_type & bits_left
                     & (bit_cnt != 4'h0) & is_slave;                 // RULE19
    wire last_cap  = capture & (bit_cnt == LAST_BIT);
    wire m_end     = m_edge & (edge_cnt == LAST_EDGE);               // RULE19
    wire s_last    = last_cap & is_slave;
    wire scs_rise  = scs_s & ~scs_d;
    wire s_abort   = pins_on & is_slave & select_pin_enable & scs_rise
                     & (bit_cnt != 4'h0) & ~s_last;
    wire busy      = (state == ST_SHIFT) | (|take_dly)
                     | (is_slave & (bit_cnt != 4'h0));
    wire start     = wr_data & ~busy & engine_on & is_master;        // RULE3
    wire ev_done   = done_dly[1] | s_last | s_abort;                 // RULE16
    wire ev_coll   = wr_data & busy & engine_on;                     // RULE17
    wire ev_inc    = s_abort;
    wire [2:0] ev_vec = {ev_inc, ev_coll, ev_done};
    wire [2:0] stat_clr = wr_stat ? hwdata[2:0] : 3'h0;

    sspi_rate #(
        .SUB_HALF (SUB_HALF)
    ) u_rate (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .run         (state == ST_SHIFT),
        .mode        (port_mode_field),
        .timer_match (timer_match),
        .half_tick   (half_tick)
    );

    // ----------------
    // ahb-lite slave: writes zero wait, reads one wait state
    // ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            rd_wait  <= 1'b0;
            dp_addr  <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else begin
            dp_write <= acc & hwrite;
            if (acc) begin
                dp_addr <= haddr[7:0];
                rd_wait <= ~hwrite;
            end else begin
                rd_wait <= 1'b0;
            end
            if (rd_wait) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;
    assign irq       = |(irq_status & irq_mask);

    // ----------------
    // control registers; hardware set wins over a software clear
    // ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_mode_field        <= MODE_RST;
            twowire_debounce_field <= DEB_RST;
            module_enable_bit      <= 1'b0;
            slave_incomplete_flag  <= 1'b0;
            spare_bits             <= SPARE_RST;
            clock_idle_polarity    <= 1'b0;
            capture_edge_select    <= 1'b0;
            bit_order_select       <= 1'b0;
            select_pin_enable      <= 1'b0;
            write_collision_flag   <= 1'b0;
            transfer_done_flag     <= 1'b0;
            irq_status             <= 3'h0;
            irq_mask               <= MASK_RST;
        end else begin
            if (wr_a) begin
                port_mode_field        <= hwdata[CA_MODE_LSB +: 3];  // RULE1
                twowire_debounce_field <= hwdata[CA_DEB_LSB +: 2];
                module_enable_bit      <= hwdata[CA_EN];             // RULE6
            end
            slave_incomplete_flag <= ev_inc
                | (wr_a ? hwdata[CA_INC] : slave_incomplete_flag);
            if (wr_b) begin
                spare_bits          <= hwdata[CB_SPARE_LSB +: 2];
                clock_idle_polarity <= hwdata[CB_POL];               // RULE18
                capture_edge_select <= hwdata[CB_EDGE];              // RULE8
                bit_order_select    <= hwdata[CB_ORDER];             // RULE7
                select_pin_enable   <= hwdata[CB_SELECT_PIN_ENABLE];              // RULE5
            end
            write_collision_flag <= ev_coll
                | (wr_b ? hwdata[CB_WRITE_COLLISION_FLAG] : write_collision_flag);   // RULE17
            transfer_done_flag <= ev_done
                | (wr_b ? hwdata[CB_TRF] : transfer_done_flag);      // RULE16
            irq_status <= (irq_status & ~stat_clr) | ev_vec;
            if (wr_mask) begin
                irq_mask <= hwdata[2:0];
            end
        end
    end

    // ----------------
    // data buffer doubles as the shift register
    // ----------------
    // one buffer saves a byte, but mid-transfer reads show partial data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_data_buffer <= DATA_RST;
        end else if (wr_data && !busy) begin
            serial_data_buffer <= hwdata[7:0];                       // RULE10
        end else if (s_last || take_dly[1]) begin
            serial_data_buffer <= shift_in(serial_data_buffer, sdi_s,
                                           bit_order_select);        // RULE11
        end else if (shift_ev) begin
            serial_data_buffer <= shift_in(serial_data_buffer, cap_bit,
                                           bit_order_select);        // RULE9
        end
    end

    // ----------------
    // transfer engine
    // ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= ST_IDLE;
            edge_cnt <= 5'h00;
            bit_cnt  <= 4'h0;
            cap_bit  <= 1'b0;
            sck_lvl  <= 1'b1;
            sck_d    <= 1'b0;
            scs_d    <= 1'b1;
            take_dly <= 2'h0;
            done_dly <= 2'h0;
        end else begin
            sck_d <= sck_s;
            scs_d <= scs_s;
            take_dly <= engine_on ? {take_dly[0], capture & is_master} : 2'h0;
            done_dly <= engine_on ? {done_dly[0], m_end} : 2'h0;
            if (!engine_on) begin
                state    <= ST_IDLE;                                 // RULE6
                edge_cnt <= 5'h00;
                bit_cnt  <= 4'h0;
                sck_lvl  <= idle_lvl;
            end else begin
                if (state == ST_IDLE) begin
                    sck_lvl <= idle_lvl;                             // RULE18
                end
                if (start) begin
                    state    <= ST_SHIFT;                            // RULE2
                    edge_cnt <= 5'h00;
                    bit_cnt  <= 4'h0;
                end
                if (m_edge) begin
                    sck_lvl  <= ~sck_lvl;                            // RULE3
                    edge_cnt <= edge_cnt + 5'h01;
                end
                if (capture) begin
                    cap_bit <= sdi_s;                                // RULE2
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (m_end) begin
                    state   <= ST_IDLE;
                    bit_cnt <= 4'h0;
                end
                if (s_last || s_abort) begin
                    bit_cnt <= 4'h0;
                end
            end
        end
    end

    // ----------------
    // pins
    // ----------------
    assign sck_out            = sck_lvl;
    assign sck_oe             = pins_on & is_master;                 // RULE14
    assign sdo_out            = bit_order_select ? serial_data_buffer[7]
                                                 : serial_data_buffer[0];
    assign sdo_oe             = pins_on & (is_master
                                | (is_slave & slave_sel));           // RULE12
    // one select line only; extra slaves need general purpose pins
    assign slave_select_n_out = ~(state == ST_SHIFT);                // RULE4
    assign slave_select_n_oe  = pins_on & is_master
                                & select_pin_enable;                 // RULE14
endmodule

// >>> sspi_props.sv
// assertion checker of the spi serial port, bound into its top module
`timescale 1ns/1ps
module sspi_props
    import sspi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pin_func_sel,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_oe,
    input wire logic slave_select_n_out,
    input wire logic slave_select_n_oe
);
    default clocking cb_main @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------
    // helper: serial clock toggles seen while the select is low
    // ----------------
    logic       [4:0] edge_cnt;
    logic             sck_prev;
    wire logic        sck_moved  = sck_out != sck_prev;
    wire logic  [4:0] seen_edges = edge_cnt + {4'h0, sck_moved};
    wire logic  [4:0] next_edges = slave_select_n_out ? 5'h00 : seen_edges;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_cnt <= 5'h00;
            sck_prev <= 1'b1;
        end else begin
            edge_cnt <= next_edges;
            sck_prev <= sck_out;
        end
    end
    // ----------------
    // properties
    // ----------------
    pins_off_a: assert property (
        !pin_func_sel |-> !(sck_oe || sdo_oe || slave_select_n_oe))
        else $error("pin driven while pins not assigned");
    sel_master_a: assert property (
        slave_select_n_oe |-> sck_oe && sdo_oe)
        else $error("select driven outside master drive");
    xfer_start_a: assert property (
        $fell(slave_select_n_out) |-> sck_oe)
        else $error("transfer started without driving the clock");
    sel_hold_a: assert property (
        $fell(slave_select_n_out) |-> !slave_select_n_out [*8])
        else $error("select released too early");
    edge_count_a: assert property (
        $rose(slave_select_n_out) && sck_oe |-> seen_edges == 5'h10)
        else $error("transfer did not have sixteen clock edges");
    half_min_a: assert property (
        sck_oe && $changed(sck_out) |=> $stable(sck_out))
        else $error("serial clock half period shorter than two cycles");
    wait_one_a: assert property (!hreadyout |=> hreadyout)
        else $error("bus wait longer than one cycle");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    cover property ($fell(slave_select_n_out));
    cover property ($rose(slave_select_n_out) && sck_oe);
    cover property (!pin_func_sel);
endmodule

bind sspi_top sspi_props i_sspi_props (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .pin_func_sel(pin_func_sel), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo_oe(sdo_oe), .slave_select_n_out(slave_select_n_out),
    .slave_select_n_oe(slave_select_n_oe));

// >>> sspi_peer.sv
// external spi slave answering the port in its master modes
`timescale 1ns/1ps
module sspi_peer (
    input  wire logic       sck,       // only an input here
    input  wire logic       sel_n,
    input  wire logic       mosi,
    input  wire logic       msb_first,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic      [7:0] rx
);
    int n = 0;
    initial begin
        miso = 1'b0;
        rx   = 8'h00;
    end
    // first bit must stand before the first capture edge
    always @(negedge sel_n) begin
        n    = 0;
        miso = tx[msb_first ? 7 : 0];
    end
    always @(posedge sck) begin
        if (!sel_n || n == 7) begin
            rx = msb_first ? {rx[6:0], mosi} : {mosi, rx[7:1]};
            n  = n + 1;
        end
    end
    always @(negedge sck) begin
        if (!sel_n && n > 0 && n < 8) begin
            miso = tx[msb_first ? 7 - n : n];
        end
    end
    // released line shows the inverse so a stale bit never passes
    always @(posedge sel_n) begin
        miso = ~miso;
    end
endmodule

// >>> sspi_top_test.sv
// self-checking bench of the spi serial port with bus master and peer
`timescale 1ns/1ps
module sspi_top_test
    import sspi_pkg::*;
();
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, tcnt = 2'h0;
    logic        pin_func_sel = 1'b1, timer_match = 1'b0, peer_msb = 1'b1;
    logic        s_sck = 1'b1, s_sdi = 1'b0, slv = 1'b0;
    logic [7:0]  peer_tx = 8'h00, peer_rx, got;
    logic        hreadyout, hresp, irq, sck_out, sck_oe, sdo_out, sdo_oe;
    logic        ss_out, ss_oe, peer_miso;
    int          err_count = 0, checks = 0;
    wire logic   sck_w = sck_oe ? sck_out : s_sck;
    wire logic   ss_w  = ss_oe ? ss_out : 1'b1; // select has a pull-up
    wire logic   sdi_w = slv ? s_sdi : peer_miso;
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        tcnt        <= tcnt + 2'h1;
        timer_match <= (tcnt == 2'h3);
    end
    sspi_top #(.SUB_HALF(16'h0004)) i_sspi_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .pin_func_sel(pin_func_sel),
        .timer_match(timer_match), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .sdi_in(sdi_w), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .slave_select_n_in(ss_w),
        .slave_select_n_out(ss_out), .slave_select_n_oe(ss_oe));
    sspi_peer i_sspi_peer (.sck(sck_w), .sel_n(ss_w), .mosi(sdo_out),
        .msb_first(peer_msb), .tx(peer_tx), .miso(peer_miso), .rx(peer_rx));
    // ----------------
    // bus and check tasks
    // ----------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic waitrdy;
        int t;
        t = 0;
        do begin
            @(posedge hclk);
            t++;
            if (t > 40) begin
                err_count++;
                end_sim();
            end
        end while (hreadyout !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        waitrdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitrdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        ahb(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rdchk(input string s, input logic [7:0] a, e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(s, {24'h0, e}, q);
    endtask
    task automatic wait_done;
        logic [31:0] q;
        int          t;
        q = 32'h0;
        t = 0;
        while (q[CB_TRF] !== 1'b1) begin
            ahb(1'b0, OFS_CTRL_B, 32'h0, q);
            t++;
            if (t > 400) begin
                err_count++;
                end_sim();
            end
        end
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        logic [7:0] cb;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("ctrl_a", OFS_CTRL_A, 8'he0);
        rdchk("ctrl_b", OFS_CTRL_B, 8'h00);
        rdchk("data", OFS_DATA, DATA_RST);
        rdchk("unmapped", 8'h14, 8'h00);
        wr(OFS_IRQ_MASK, 8'h03);
        $display("test reset values done");
        for (int m = 0; m < 5; m++) begin
            cb = m[0] ? 8'h0c : 8'h04;
            peer_msb <= m[0];
            peer_tx  <= 8'h3c + 8'(m);
            wr(OFS_CTRL_B, cb);
            wr(OFS_CTRL_A, {3'(m), 5'h02});
            wr(OFS_DATA, 8'ha5 ^ 8'(m));
            wr(OFS_DATA, 8'hff);
            wait_done();
            rdchk("rx byte", OFS_DATA, 8'h3c + 8'(m));
            chk("peer rx", {24'h0, 8'ha5 ^ 8'(m)}, {24'h0, peer_rx});
            rdchk("flags", OFS_CTRL_B, cb | 8'h03);
            rdchk("status", OFS_IRQ_STAT, 8'h03);
            @(negedge hclk);
            chk("irq", 32'h1, {31'h0, irq});
            @(posedge hclk);
            wr(OFS_IRQ_STAT, 8'h03);
            wr(OFS_CTRL_B, cb);
            @(negedge hclk);
            chk("irq off", 32'h0, {31'h0, irq});
            chk("idle sck", 32'h1, {31'h0, sck_out});
            @(posedge hclk);
        end
        $display("test master modes done");
        wr(OFS_CTRL_B, 8'h20);
        pin_func_sel <= 1'b0;
        repeat (2) @(negedge hclk);
        chk("idle sck low", 32'h0, {31'h0, sck_out});
        chk("pin drive", 32'h0, {29'h0, sck_oe, sdo_oe, ss_oe});
        @(posedge hclk);
        pin_func_sel <= 1'b1;
        wr(OFS_CTRL_B, 8'h0c);
        wr(OFS_CTRL_A, 8'h42);
        wr(OFS_DATA, 8'h5a);
        repeat (20) @(posedge hclk);
        wr(OFS_CTRL_A, 8'h40);
        repeat (2) @(negedge hclk);
        chk("abort select", 32'h1, {31'h0, ss_out});
        @(posedge hclk);
        rdchk("cfg kept", OFS_CTRL_B, 8'h0c);
        $display("test abort done");
        wr(OFS_CTRL_B, 8'h08);
        wr(OFS_CTRL_A, 8'ha2);
        wr(OFS_DATA, 8'hc3);
        slv <= 1'b1;
        cb = 8'h96;
        for (int i = 7; i >= 0; i--) begin
            repeat (16) @(posedge hclk);
            s_sck <= 1'b0;
            s_sdi <= cb[i];
            repeat (16) @(posedge hclk);
            s_sck <= 1'b1;
            got[i] = sdo_out;
        end
        wait_done();
        rdchk("slave rx", OFS_DATA, 8'h96);
        chk("slave tx", 32'hc3, {24'h0, got});
        chk("slave clock", 32'h0, {31'h0, sck_oe});
        $display("test slave mode done");
        end_sim();
    end
endmodule
